/* core/tcrc_pkg.sv */
// package: register map, field layout and decodes of the crc/rx_baud_config
package tcrc_pkg;
  localparam logic [7:0] addr_tx_crc_config = 8'h19;
  localparam logic [7:0] addr_rx_baud_config = 8'h1A;
  localparam logic [7:0] addr_rx_card_mode_config = 8'h1B;
  localparam logic [7:0] addr_tx_wait_config = 8'h17;
  // tx crc config fields
  localparam int crc_preset_value_lsb = 16;
  localparam int crc_skip_first_byte_bit = 6;
  localparam int crc_preset_sel_lsb = 3;
  localparam int crc_type_bit = 2;
  localparam int crc_invert_out_bit = 1;
  localparam int crc_enable_bit = 0;
  localparam logic [31:0] tx_crc_write_mask = 32'hFFFF007F;
  localparam logic [31:0] tx_crc_reset = 32'h00000000;
  // rx baud config
  localparam logic [31:0] rx_baud_write_mask = 32'h00000007;
  localparam logic [2:0] rx_baud_reset = 3'h0;
  localparam logic [2:0] baud_106 = 3'h4;
  localparam logic [2:0] baud_212 = 3'h5;
  localparam logic [2:0] baud_424 = 3'h6;
  localparam logic [2:0] baud_848 = 3'h7;
  // card mode config fields
  localparam int framing_lsb = 29;
  localparam int tap_sel_lsb = 26;
  localparam int edge_level_lsb = 13;
  localparam int bit_level_lsb = 0;
  localparam logic [31:0] card_mode_write_mask = 32'h7FFFFFFF;
  localparam logic [31:0] card_mode_reset = 32'h00000000;
  // tx wait config layout
  localparam int wait_value_lsb = 8;
  localparam logic [31:0] tx_wait_write_mask = 32'h0FFFFFFF;
  localparam logic [31:0] tx_wait_reset = 32'h00000000;
  // crc presets
  localparam logic [15:0] preset_0 = 16'h0000;
  localparam logic [15:0] preset_1 = 16'h6363;
  localparam logic [15:0] preset_2 = 16'hA671;
  localparam logic [15:0] preset_3 = 16'hFFFF;
  localparam logic [15:0] preset_4 = 16'h0012;
  localparam logic [15:0] preset_5 = 16'hE012;
  localparam logic [15:0] preset_rsvd = 16'h0000;
  localparam logic [2:0] preset_sel_custom = 3'h7;

  typedef enum logic [1:0] {
    tcrc_frm_iso_a, tcrc_frm_nfc_sync, tcrc_frm_jis, tcrc_frm_iso_b
  } tcrc_framing_type;

  // detector protocol codes
  typedef enum logic [2:0] {
    tcrc_det_a106, tcrc_det_b106, tcrc_det_jis212, tcrc_det_jis424,
    tcrc_det_nfc106
  } tcrc_proto_type;

  // edge filter tap counts by select code
  function automatic logic [5:0] tcrc_taps(input logic [2:0] sel);
    case (sel)
      3'h0: tcrc_taps = 6'h04;
      3'h1: tcrc_taps = 6'h06;
      3'h2: tcrc_taps = 6'h08;
      3'h3: tcrc_taps = 6'h0C;
      3'h4: tcrc_taps = 6'h10;
      3'h5: tcrc_taps = 6'h12;
      3'h6: tcrc_taps = 6'h18;
      default: tcrc_taps = 6'h20;
    endcase
  endfunction : tcrc_taps
endpackage : tcrc_pkg

/* core/tcrc_det_if.sv */
// interface: detector settings toward the register bank, with the load strobe driven by the bank
`timescale 1ns/1ps
`default_nettype none
interface tcrc_det_if;
  logic load;
  logic [2:0] baud;
  logic [1:0] framing;
  logic [19:0] wait_value;
  logic [7:0] wait_prescaler;
  modport map (input load, output baud, framing, wait_value, wait_prescaler);
  modport bank (output load, input baud, framing, wait_value, wait_prescaler);
endinterface : tcrc_det_if
`default_nettype wire

/* core/tcrc_det_map.sv */
// module: maps a recognised protocol to its detector settings
`timescale 1ns/1ps
`default_nettype none
module tcrc_det_map
  import tcrc_pkg::*;
(
  input wire tcrc_pkg::tcrc_proto_type proto,
  tcrc_det_if.map det
);
  always_comb begin
    det.baud = baud_106;
    det.framing = tcrc_frm_iso_a;
    det.wait_value = 20'h00000;
    det.wait_prescaler = 8'h7F;
    unique case (proto)
      tcrc_det_a106: begin
        det.baud = baud_106;
        det.framing = tcrc_frm_iso_a;
        det.wait_value = 20'h00007;
      end
      tcrc_det_b106: begin
        det.baud = baud_106;
        det.framing = tcrc_frm_iso_b;
        det.wait_value = 20'h0000A;
      end
      tcrc_det_jis212: begin
        det.baud = baud_212;
        det.framing = tcrc_frm_jis;
        det.wait_value = 20'h00010;
      end
      tcrc_det_jis424: begin
        det.baud = baud_424;
        det.framing = tcrc_frm_jis;
        det.wait_value = 20'h00010;
      end
      tcrc_det_nfc106: begin
        det.baud = baud_106;
        det.framing = tcrc_frm_nfc_sync;
        det.wait_value = 20'h00007;
      end
      default: begin
        det.baud = baud_106;
        det.framing = tcrc_frm_iso_a;
        det.wait_value = 20'h00000;
      end
    endcase
  end
endmodule : tcrc_det_map
`default_nettype wire

/* core/tcrc_config.sv */
// module: tx crc and rx signal processor configuration register bank
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// [RQ1] upper half of tx crc config holds a 16-bit arbitrary crc preset
// [RQ2] skip-first-byte bit makes crc start at the frame's second byte
// [RQ3] 3-bit preset select picks one of six fixed crc start values
// [RQ4] in 5-bit crc mode only the preset's low byte is loaded
// [RQ5] preset select 111b loads the arbitrary 16-bit preset field
// [RQ6] crc type bit: 0 selects 16-bit crc, 1 selects 5-bit crc
// [RQ7] crc invert bit sends the checksum bitwise inverted when set
// [RQ8] crc enable bit makes the encoder compute and append a crc
// [RQ9] 3-bit rx baud field: 100..111 select 106 to 848 kBd
// [RQ10] baud field msb only takes effect in reader mode
// [RQ11] auto detection writes baud 100, 101 or 110 for detected rate
// [RQ12] 2-bit framing field selects 14443A, 18092 sync, JIS, 14443B
// [RQ13] auto detection overwrites the framing field with detected framing
// [RQ14] 3-bit tap select sets edge filter length 4 to 32 taps
// [RQ15] 13-bit field holds the edge decision threshold
// [RQ16] 13-bit field holds the bit decision threshold
// [RQ17] reserved bits read zero and ignore writes
// [RQ18] auto detection also loads tx wait value and prescaler reload
module tcrc_config
  import tcrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic auto_detect_enable,
  input wire logic mode_detected,
  input wire tcrc_pkg::tcrc_proto_type detected_proto,
  input wire logic reader_mode,
  output logic crc_enable,
  output logic crc_invert_out,
  output logic crc_five_bit,
  output logic crc_skip_first_byte,
  output logic [15:0] crc_init_value,
  output logic [2:0] rx_baud,
  output logic [1:0] rx_framing,
  output logic [5:0] edge_filter_taps,
  output logic [12:0] edge_decision_level,
  output logic [12:0] bit_decision_level,
  output logic [19:0] tx_wait_value,
  output logic [7:0] tx_wait_prescaler
);
  import tcrc_pkg::*;

  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    logic [31:0] tx_crc_config;
    logic [2:0] rx_baud_config;
    logic [31:0] rx_card_mode_config;
    logic [31:0] tx_wait_config;
    logic [31:0] rdata;
    logic crc_enable;
    logic crc_invert_out;
    logic crc_five_bit;
    logic crc_skip_first_byte;
    logic [15:0] crc_init_value;
    logic [2:0] rx_baud;
    logic [1:0] rx_framing;
    logic [5:0] edge_filter_taps;
    logic [12:0] edge_decision_level;
    logic [12:0] bit_decision_level;
    logic [19:0] tx_wait_value;
    logic [7:0] tx_wait_prescaler;
  } tcrc_state_type;

  tcrc_state_type state;
  tcrc_state_type next_state;

  tcrc_det_if det ();

  tcrc_det_map u_map (
    .proto(detected_proto),
    .det(det.map)
  );

  assign det.load = auto_detect_enable & mode_detected;

  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic logic [31:0] masked_write(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [31:0] mask);
    masked_write = (wd & mask) | (old & ~mask);
  endfunction : masked_write

  function automatic logic [15:0] preset_lookup(input logic [2:0] sel,
                                                input logic [15:0] custom);
    case (sel)
      3'h0: preset_lookup = preset_0;
      3'h1: preset_lookup = preset_1;
      3'h2: preset_lookup = preset_2;
      3'h3: preset_lookup = preset_3;
      3'h4: preset_lookup = preset_4;
      3'h5: preset_lookup = preset_5;
      3'h6: preset_lookup = preset_rsvd;
      default: preset_lookup = custom;
    endcase
  endfunction : preset_lookup

  // ********************************************************************
  // next state
  // ********************************************************************
  logic [15:0] preset_full;
  logic [2:0] preset_sel;
  logic [2:0] baud_eff;

  always_comb begin
    next_state = state;
    preset_sel = 3'h0;
    preset_full = 16'h0000;
    baud_eff = 3'h0;

    // software writes; reserved bits keep zero through the masks
    if (reg_write) begin
      unique case (reg_addr)
        addr_tx_crc_config: begin
          next_state.tx_crc_config = masked_write(state.tx_crc_config,
            reg_wdata, tx_crc_write_mask); // RQ1 RQ17
        end
        addr_rx_baud_config: begin
          next_state.rx_baud_config = reg_wdata[2:0]; // RQ9 RQ17
        end
        addr_rx_card_mode_config: begin
          next_state.rx_card_mode_config = masked_write(
            state.rx_card_mode_config, reg_wdata,
            card_mode_write_mask); // RQ17
        end
        addr_tx_wait_config: begin
          next_state.tx_wait_config = masked_write(state.tx_wait_config,
            reg_wdata, tx_wait_write_mask);
        end
        default: begin
        end
      endcase
    end

    // detector has the last word: a same-cycle software write to baud, framing or tx wait loses,
    // since the detected protocol is what the link is actually using
    if (det.load) begin
      next_state.rx_baud_config = det.baud; // RQ11
      next_state.rx_card_mode_config[framing_lsb +: 2] =
        det.framing; // RQ13
      next_state.tx_wait_config = {4'h0, det.wait_value,
        det.wait_prescaler}; // RQ18
    end

    // read data, valid only in the cycle after the strobe
    next_state.rdata = 32'h00000000;
    if (reg_read) begin
      unique case (reg_addr)
        addr_tx_crc_config: next_state.rdata = state.tx_crc_config;
        addr_rx_baud_config: next_state.rdata = {29'h0,
          state.rx_baud_config};
        addr_rx_card_mode_config: next_state.rdata =
          state.rx_card_mode_config;
        addr_tx_wait_config: next_state.rdata = state.tx_wait_config;
        default: next_state.rdata = 32'h00000000;
      endcase
    end

    // decoded controls from the registers as they now stand
    preset_sel = state.tx_crc_config[crc_preset_sel_lsb +: 3];
    preset_full = preset_lookup(preset_sel,
      state.tx_crc_config[crc_preset_value_lsb +: 16]); // RQ3 RQ5
    next_state.crc_five_bit = state.tx_crc_config[crc_type_bit]; // RQ6
    next_state.crc_init_value = state.tx_crc_config[crc_type_bit] ?
      {8'h00, preset_full[7:0]} : preset_full; // RQ4
    next_state.crc_enable = state.tx_crc_config[crc_enable_bit]; // RQ8
    next_state.crc_invert_out =
      state.tx_crc_config[crc_invert_out_bit]; // RQ7
    next_state.crc_skip_first_byte =
      state.tx_crc_config[crc_skip_first_byte_bit]; // RQ2

    // outside reader mode the msb is forced to 1: 001 reads as 101 (212) etc.
    baud_eff = state.rx_baud_config;
    if (!reader_mode) begin
      baud_eff[2] = 1'b1; // RQ10
    end
    next_state.rx_baud = reader_mode ? state.rx_baud_config :
      {1'b1, state.rx_baud_config[1:0]}; // RQ10 RQ9
    next_state.rx_framing =
      state.rx_card_mode_config[framing_lsb +: 2]; // RQ12
    next_state.edge_filter_taps = tcrc_taps(
      state.rx_card_mode_config[tap_sel_lsb +: 3]); // RQ14
    next_state.edge_decision_level =
      state.rx_card_mode_config[edge_level_lsb +: 13]; // RQ15
    next_state.bit_decision_level =
      state.rx_card_mode_config[bit_level_lsb +: 13]; // RQ16
    next_state.tx_wait_value = state.tx_wait_config[wait_value_lsb +: 20];
    next_state.tx_wait_prescaler = state.tx_wait_config[7:0];
  end

  // ********************************************************************
  // registers
  // ********************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
      state.tx_crc_config <= tx_crc_reset;
      state.rx_baud_config <= rx_baud_reset;
      state.rx_card_mode_config <= card_mode_reset;
      state.tx_wait_config <= tx_wait_reset;
      state.edge_filter_taps <= 6'h04;
      state.rx_baud <= 3'h4;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign crc_enable = state.crc_enable;
  assign crc_invert_out = state.crc_invert_out;
  assign crc_five_bit = state.crc_five_bit;
  assign crc_skip_first_byte = state.crc_skip_first_byte;
  assign crc_init_value = state.crc_init_value;
  assign rx_baud = state.rx_baud;
  assign rx_framing = state.rx_framing;
  assign edge_filter_taps = state.edge_filter_taps;
  assign edge_decision_level = state.edge_decision_level;
  assign bit_decision_level = state.bit_decision_level;
  assign tx_wait_value = state.tx_wait_value;
  assign tx_wait_prescaler = state.tx_wait_prescaler;
endmodule : tcrc_config
`default_nettype wire

/* bench/tcrc_config_asserts.sv */
// checker: port-level properties of the crc and rx_baud_config bank
`timescale 1ns/1ps
`default_nettype none
module tcrc_config_asserts
  import tcrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic auto_detect_enable,
  input wire logic mode_detected,
  input wire tcrc_pkg::tcrc_proto_type detected_proto,
  input wire logic reader_mode,
  input wire logic crc_five_bit,
  input wire logic [15:0] crc_init_value,
  input wire logic [2:0] rx_baud,
  input wire logic [5:0] edge_filter_taps,
  input wire logic [12:0] edge_decision_level,
  input wire logic [12:0] bit_decision_level
);
  // write data two edges back, lined up with the decoded outputs
  logic [31:0] wd_q;
  logic [31:0] wd_qq;
  always_ff @(posedge clk) begin
    wd_q <= reg_wdata;
    wd_qq <= wd_q;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] a);
    reg_write && reg_addr == a;
  endsequence
  sequence s_det(tcrc_proto_type p);
    auto_detect_enable && mode_detected && detected_proto == p;
  endsequence
  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 32'h0) else $error("rdata not idle");
  a_unmapped_read: assert property (
    reg_read && reg_addr > 8'h1B |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_custom_preset: assert property (
    s_wr(8'h19) ##0 reg_wdata[5:2] == 4'hE |-> ##2
    crc_init_value == wd_qq[31:16]) else $error("custom preset wrong");
  a_five_bit_byte: assert property (
    crc_five_bit |-> crc_init_value[15:8] == 8'h00)
    else $error("five bit preset high byte set");
  a_baud_msb_fixed: assert property (
    !$past(reader_mode) |-> rx_baud[2]) else $error("baud msb not fixed");
  a_detect_jis_baud: assert property (
    s_det(tcrc_det_jis212) |-> ##2 rx_baud == 3'h5)
    else $error("detected baud wrong");
  a_levels_follow: assert property (
    s_wr(8'h1B) |-> ##2 edge_decision_level == wd_qq[25:13] &&
    bit_decision_level == wd_qq[12:0]) else $error("levels wrong");
  a_taps_legal: assert property (
    edge_filter_taps inside {6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h12,
    6'h18, 6'h20}) else $error("tap count illegal");
endmodule : tcrc_config_asserts
bind tcrc_config tcrc_config_asserts chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata),
  .auto_detect_enable(auto_detect_enable), .mode_detected(mode_detected),
  .detected_proto(detected_proto), .reader_mode(reader_mode),
  .crc_five_bit(crc_five_bit), .crc_init_value(crc_init_value),
  .rx_baud(rx_baud), .edge_filter_taps(edge_filter_taps),
  .edge_decision_level(edge_decision_level),
  .bit_decision_level(bit_decision_level));
`default_nettype wire

/* bench/tcrc_config_test.sv */
// testbench: register, decode and detector scenarios of the config bank
`timescale 1ns/1ps
`default_nettype none
module tcrc_config_test;
  import tcrc_pkg::*;
  logic clk = 0, rst = 1, reg_write = 0, reg_read = 0, reader_mode = 0;
  logic auto_detect_enable = 0, mode_detected = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  tcrc_proto_type detected_proto = tcrc_det_a106;
  logic crc_enable, crc_invert_out, crc_five_bit, crc_skip_first_byte;
  logic [15:0] crc_init_value;
  logic [2:0] rx_baud;
  logic [1:0] rx_framing;
  logic [5:0] edge_filter_taps;
  logic [12:0] edge_decision_level, bit_decision_level;
  logic [19:0] tx_wait_value;
  logic [7:0] tx_wait_prescaler;
  int failures = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  tcrc_config dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .auto_detect_enable(auto_detect_enable),
    .mode_detected(mode_detected), .detected_proto(detected_proto),
    .reader_mode(reader_mode), .crc_enable(crc_enable),
    .crc_invert_out(crc_invert_out), .crc_five_bit(crc_five_bit),
    .crc_skip_first_byte(crc_skip_first_byte),
    .crc_init_value(crc_init_value), .rx_baud(rx_baud),
    .rx_framing(rx_framing), .edge_filter_taps(edge_filter_taps),
    .edge_decision_level(edge_decision_level),
    .bit_decision_level(bit_decision_level),
    .tx_wait_value(tx_wait_value), .tx_wait_prescaler(tx_wait_prescaler));
  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // returns once the decoded outputs carry the new value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
    #1;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd_chk
  task automatic det(input tcrc_proto_type p);
    @(posedge clk);
    mode_detected <= 1'b1;
    detected_proto <= p;
    @(posedge clk);
    mode_detected <= 1'b0;
    @(posedge clk);
    #1;
  endtask : det
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    check(edge_filter_taps, 6'h04);
    check(rx_baud, 3'h4);
    check({crc_init_value, crc_enable}, 17'h0);
    rd_chk(8'h19, 32'h0);
    rd_chk(8'h1A, 32'h0);
    rd_chk(8'h1B, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_crc;
    logic [15:0] pre [8] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF,
      16'h0012, 16'hE012, 16'h0000, 16'hBEEF};
    for (int i = 0; i < 8; i++) begin
      wr(8'h19, {16'hBEEF, 10'h0, i[2:0], 3'b000});
      check(crc_init_value, pre[i]);
      check({crc_skip_first_byte, crc_five_bit}, 2'h0);
      wr(8'h19, {16'hBEEF, 9'h0, 1'b1, i[2:0], 3'b111});
      check(crc_init_value, {8'h00, pre[i][7:0]});
      check({crc_skip_first_byte, crc_five_bit, crc_invert_out}, 3'h7);
    end
    wr(8'h19, 32'h00000041);
    check({crc_skip_first_byte, crc_five_bit, crc_enable}, 3'h5);
    wr(8'h19, 32'hFFFFFFFF);
    rd_chk(8'h19, 32'hFFFF007F);
    $display("crc test done");
  endtask : t_crc
  task automatic t_baud;
    @(posedge clk);
    reader_mode <= 1'b1;
    for (int i = 1; i < 8; i++) begin
      wr(8'h1A, 32'hFFFFFFF8 | i);
      check(rx_baud, i[2:0]);
    end
    rd_chk(8'h1A, 32'h7);
    wr(8'h1A, 32'h1);
    @(posedge clk);
    reader_mode <= 1'b0;
    @(posedge clk);
    #1;
    check(rx_baud, 3'h5);
    $display("baud test done");
  endtask : t_baud
  task automatic t_card;
    logic [5:0] taps [8] = '{6'd4, 6'd6, 6'd8, 6'd12, 6'd16, 6'd18, 6'd24,
      6'd32};
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {1'b1, i[1:0], i[2:0], 13'h1ABC - i[12:0], 13'h0055 + i[12:0]};
      wr(8'h1B, d);
      check(edge_filter_taps, taps[i]);
      check(rx_framing, i[1:0]);
      check(edge_decision_level, d[25:13]);
      check(bit_decision_level, d[12:0]);
      rd_chk(8'h1B, {1'b0, d[30:0]});
    end
    $display("card mode test done");
  endtask : t_card
  task automatic t_detect;
    logic [2:0] eb [5] = '{3'h4, 3'h4, 3'h5, 3'h6, 3'h4};
    logic [1:0] ef [5] = '{2'h0, 2'h3, 2'h2, 2'h2, 2'h1};
    logic [19:0] ew [5] = '{20'h7, 20'hA, 20'h10, 20'h10, 20'h7};
    @(posedge clk);
    auto_detect_enable <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      det(tcrc_proto_type'(i));
      check(rx_baud, eb[i]);
      check(rx_framing, ef[i]);
      check({tx_wait_value, tx_wait_prescaler}, {ew[i], 8'h7F});
    end
    @(posedge clk);
    auto_detect_enable <= 1'b0;
    det(tcrc_det_b106);
    check(rx_framing, 2'h1);
    wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h0);
    rd_chk(8'h1A, 32'h4);
    $display("detector test done");
  endtask : t_detect
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset;
    t_crc;
    t_baud;
    t_card;
    t_detect;
    test_done;
  end
  // a stuck run is cut short and counted as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done;
  end
endmodule : tcrc_config_test
`default_nettype wire
